// >>> bench/lrc_panel_model.sv
// panel column/row driver chip model
`timescale 1ns/1ps
`default_nettype none
module lrc_panel_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] col_data,
  input  wire logic       col_shift,
  input  wire logic       ecl,
  input  wire logic       latch,
  input  wire logic       row_clk,
  input  wire logic       frame_row,
  output logic [3:0]      cap_nib,
  output logic            cap_stb,
  output int              shifts,
  output int              ecls,
  output int              lines,
  output int              frames
);
  logic [3:0] prev_q;
  // edges are found on the core clock, since every panel output is registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
      cap_stb <= 1'b0;
      cap_nib <= '0;
      {shifts, ecls, lines, frames} <= '0;
    end else begin
      prev_q <= {col_shift, ecl, latch, row_clk};
      cap_stb <= prev_q[3] & !col_shift;
      cap_nib <= col_data;
      shifts <= shifts + int'(prev_q[3] & !col_shift);
      ecls <= ecls + int'(prev_q[2] & !ecl);
      lines <= lines + int'(prev_q[1] & !latch);
      frames <= frames + int'(prev_q[0] & !row_clk & frame_row);
    end
  end
endmodule : lrc_panel_model
`default_nettype wire

// >>> bench/tb_lrc_timing.sv
// self-checking bench for the panel timing generator
`timescale 1ns/1ps
`default_nettype none
module tb_lrc_timing;
  logic        clock = 0, rst = 1, clk_en = 1, psave = 0, take, shc, ecl, lat, bb, rsc, frp, rdd;
  logic        stb, pb, en_q = 1'b0;
  logic [3:0]  pix_q = '0;
  logic [11:0] chars = 12'h0010, lpf = 12'h0002, bias = 12'h0001;
  logic [3:0]  pix = '0, cdn, cap;
  int          shifts, ecls, lines, frames, err_total = 0, checks_done = 0;
  int          ls, le, pl, bl, ps;
  logic [3:0]  expq[$];
  always #5 clock = ~clock;
  lrc_timing i_lrc_timing (.clock(clock), .rst(rst), .clk_en(clk_en), .chars_per_line(chars),
    .lines_per_frame(lpf), .bias_period(bias), .power_save(psave), .pixel_nibble(pix),
    .pixel_take(take), .column_data_nibble(cdn), .column_shift_clock(shc),
    .column_enable_chain_clock(ecl), .line_latch_pulse(lat), .backplane_bias_toggle(bb),
    .row_shift_clock(rsc), .frame_row_pulse(frp), .row_driver_disable(rdd));
  lrc_panel_model i_lrc_panel_model (.clock(clock), .rst(rst), .col_data(cdn), .col_shift(shc),
    .ecl(ecl), .latch(lat), .row_clk(rsc), .frame_row(frp), .cap_nib(cap), .cap_stb(stb),
    .shifts(shifts), .ecls(ecls), .lines(lines), .frames(frames));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // random pixels and clock-enable gaps, driven just after the edge;
  // a take seen now was set by the last edge, so queue the nibble that stood then
  always @(posedge clock) begin
    if (take === 1'b1 && en_q) expq.push_back(pix_q);
    pix_q = pix;
    en_q  = clk_en;
    #1 pix <= 4'($urandom);
    clk_en <= ($urandom % 8) != 0;
  end
  // compare on the falling edge, after the model's counters have settled
  always @(negedge clock) begin
    if (rst) begin
      check("reset outputs", {shc, lat, frp, rdd}, 0);
      {ls, le, pl, bl} = '0;
      pb = 1'bx;
      expq.delete();
    end else begin
      if (lat === 1'b1) check("shift clock stopped", shc, 0);
      if (stb === 1'b1) check("nibble", cap, expq.pop_front());
      if (bb !== pb && pb !== 1'bx && bl > 0) check("bias period", lines - bl, bias);
      if (bb !== pb && pb !== 1'bx) bl = lines;
      pb = bb;
      if (lines != pl) begin
        check("shifts per line", shifts - ls, chars);
        check("ecl per line", ecls - le, chars / 16);
        if (lines % lpf == 1) check("frame pulses", frames, lines / lpf);
        if (!psave) check("row drive on", rdd, 1);
        {ls, le, pl} = {shifts, ecls, lines};
      end
    end
  end
  initial begin
    void'($urandom(33));
    for (int r = 0; r < 4; r++) begin
      #1 rst = 1;
      psave = 0;
      repeat (4) @(posedge clock);
      #1 chars = (r == 0) ? 12'h0010 : (r == 1) ? 12'h0001 : 12'($urandom_range(40, 2));
      lpf = 12'($urandom_range(4, 2));
      bias = 12'($urandom_range(3, 1));
      rst = 0;
      for (int i = 0; i < 20000 && lines < 4 * lpf; i++) @(posedge clock);
      #1 psave = 1;
      ps = lines;
      for (int i = 0; i < 20000 && rdd !== 1'b0; i++) @(posedge clock);
      check("blank within two frames", (rdd === 1'b0) && (lines - ps <= 2 * lpf), 1);
    end
    end_of_test();
  end
  // watchdog: four rounds of a few thousand cycles each, 90k cycles is ample
  initial begin
    #900000;
    err_total++;
    end_of_test();
  end
endmodule : tb_lrc_timing
`default_nettype wire

// >>> hdl/lrc_pkg.sv
// constants for the panel row/column timing generator
package lrc_pkg;
  localparam int          NIB_W        = 4;
  localparam int          CNT_W        = 12;
  localparam int          ECL_SPAN     = 16;
  localparam logic [3:0]  ECL_LAST     = 4'h000F;
  localparam logic [1:0]  SHIFT_DIV    = 2'h1;
  localparam logic [CNT_W-1:0] LATCH_CYC = 12'h0004;
  typedef enum logic [1:0] {LRC_IDLE, LRC_SHIFT, LRC_LATCH} lrc_state_t;
endpackage : lrc_pkg

// >>> hdl/lrc_timing.sv
// panel row/column driver timing generator
`timescale 1ns/1ps
`default_nettype none
module lrc_timing
  import lrc_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [CW-1:0]    chars_per_line,
  input  wire logic [CW-1:0]    lines_per_frame,
  input  wire logic [CW-1:0]    bias_period,
  input  wire logic             power_save,
  input  wire logic [NIB_W-1:0] pixel_nibble,
  output logic                  pixel_take,
  output logic [NIB_W-1:0]      column_data_nibble,
  output logic                  column_shift_clock,
  output logic                  column_enable_chain_clock,
  output logic                  line_latch_pulse,
  output logic                  backplane_bias_toggle,
  output logic                  row_shift_clock,
  output logic                  frame_row_pulse,
  output logic                  row_driver_disable
);
  lrc_state_t      state_q;
  logic [CW-1:0]   col_q;
  logic [CW-1:0]   line_q;
  logic [CW-1:0]   lat_q;
  logic [CW-1:0]   bias_q;
  logic [3:0]      ecl_q;
  logic [1:0]      save_q;
  logic            save_seen_q;

  function automatic logic at_last(input logic [CW-1:0] v, input logic [CW-1:0] lim);
    at_last = (lim == '0) ? 1'b1 : (v >= lim - 1'b1);
  endfunction : at_last

  wire running = !save_q[1] || row_driver_disable;
  wire end_line = (state_q == LRC_LATCH) && at_last(lat_q, LATCH_CYC);
  wire end_frame = end_line && at_last(line_q, lines_per_frame);

  // line sequencer: shift phase then latch phase, counters on core clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q            <= LRC_IDLE;
      col_q              <= '0;
      lat_q              <= '0;
      column_shift_clock <= 1'b0;
      column_data_nibble <= '0;
      pixel_take         <= 1'b0;
      line_latch_pulse   <= 1'b0;
    end else if (clk_en) begin
      pixel_take <= 1'b0;
      case (state_q)
        LRC_IDLE: begin
          column_shift_clock <= 1'b0;
          if (running) state_q <= LRC_SHIFT;
        end
        LRC_SHIFT: begin
          column_shift_clock <= ~column_shift_clock;
          if (!column_shift_clock) begin
            column_data_nibble <= pixel_nibble;
            pixel_take         <= 1'b1;
          end else if (at_last(col_q, chars_per_line)) begin
            col_q            <= '0;
            lat_q            <= '0;
            state_q          <= LRC_LATCH;
            line_latch_pulse <= 1'b1;
          end else begin
            col_q <= col_q + 1'b1;
          end
        end
        LRC_LATCH: begin
          column_shift_clock <= 1'b0; // held stopped for power
          lat_q              <= lat_q + 1'b1;
          if (end_line) begin
            line_latch_pulse <= 1'b0; // falling edge latches drivers
            state_q          <= running ? LRC_SHIFT : LRC_IDLE;
          end
        end
        default: state_q <= LRC_IDLE;
      endcase
    end
  end

  // enable chain: falls after each sixteenth shift pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ecl_q                     <= '0;
      column_enable_chain_clock <= 1'b0;
    end else if (clk_en) begin
      if (state_q == LRC_SHIFT && column_shift_clock) begin
        ecl_q                     <= ecl_q + 1'b1;
        column_enable_chain_clock <= (ecl_q == ECL_LAST);
      end else if (end_line) begin
        ecl_q                     <= '0;
        column_enable_chain_clock <= 1'b0;
      end else begin
        column_enable_chain_clock <= 1'b0;
      end
    end
  end

  // line count, frame row pulse and row shift clock follow the latch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_q          <= '0;
      frame_row_pulse <= 1'b0;
      row_shift_clock <= 1'b0;
    end else if (clk_en) begin
      row_shift_clock <= line_latch_pulse; // falls one enabled cycle after the latch
      if (end_line) begin
        line_q          <= end_frame ? '0 : line_q + 1'b1;
        frame_row_pulse <= at_last(end_frame ? '0 : line_q + 1'b1,
                                   lines_per_frame);
      end
    end
  end

  // backplane bias toggles every bias_period lines
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bias_q                <= '0;
      backplane_bias_toggle <= 1'b0;
    end else if (clk_en && end_line) begin
      if (at_last(bias_q, bias_period)) begin
        bias_q                <= '0;
        backplane_bias_toggle <= ~backplane_bias_toggle;
      end else begin
        bias_q <= bias_q + 1'b1;
      end
    end
  end

  // power save: arm at the next frame end, then drop disable at the frame end after
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      save_q             <= '0;
      save_seen_q        <= 1'b0;
      row_driver_disable <= 1'b0; // low through reset
    end else if (clk_en) begin
      save_q <= {save_q[0], power_save};
      if (!save_q[1]) begin
        save_seen_q        <= 1'b0;
        row_driver_disable <= 1'b1;
      end else if (end_frame) begin
        if (save_seen_q) row_driver_disable <= 1'b0;
        save_seen_q <= 1'b1;
      end
    end
  end

  // disable may only fall at a frame boundary, within two frames
  row_dis_a: assert property (@(posedge clock) disable iff (rst)
    $fell(row_driver_disable) |-> $past(end_frame) && $past(save_q[1]))
    else $error("row disable fell outside frame end");
  latch_once_a: assert property (@(posedge clock) disable iff (rst)
    $rose(line_latch_pulse) |-> !column_shift_clock[*2])
    else $error("shift clock ran during latch");
  frame_last_a: assert property (@(posedge clock) disable iff (rst)
    $rose(frame_row_pulse) |-> $past(end_line))
    else $error("frame pulse not at line end");
  data_stable_a: assert property (@(posedge clock) disable iff (rst)
    $fell(column_shift_clock) |-> $stable(column_data_nibble))
    else $error("data moved at shift fall");
  ecl_pulse_a: assert property (@(posedge clock) disable iff (rst)
    column_enable_chain_clock && clk_en |=> !column_enable_chain_clock)
    else $error("enable chain clock too long");
  rsc_follow_a: assert property (@(posedge clock) disable iff (rst)
    clk_en |=> row_shift_clock == $past(line_latch_pulse))
    else $error("row shift clock off latch");
  idle_stop_a: assert property (@(posedge clock) disable iff (rst)
    state_q == LRC_LATCH |=> !column_shift_clock)
    else $error("shift clock not stopped");
  rdis_on_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && !save_q[1] |=> row_driver_disable)
    else $error("row disable low while active");

  // a nibble is taken on every enabled edge in the shift phase with the shift clock low
  nib_take_a: assert property (@(posedge clock) disable iff (rst)
    clk_en && state_q == LRC_SHIFT && !column_shift_clock
      |=> column_data_nibble == $past(pixel_nibble) && pixel_take)
    else $error("nibble not taken on shift rise");

  // the latch may only end out of the latch phase
  latch_len_a: assert property (@(posedge clock) disable iff (rst)
    $fell(line_latch_pulse) |-> $past(state_q) == LRC_LATCH)
    else $error("latch ended outside latch phase");

  // frame row level only moves at a line boundary
  frame_bound_a: assert property (@(posedge clock) disable iff (rst)
    $changed(frame_row_pulse) |-> $past(end_line))
    else $error("frame pulse moved mid line");

  // bias flips only at a line boundary, never mid shift
  bias_line_a: assert property (@(posedge clock) disable iff (rst)
    $changed(backplane_bias_toggle) |-> $past(end_line) && $past(clk_en))
    else $error("bias toggled off line end");

  // a low enable must freeze the sequencer and its counters
  en_freeze_a: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(state_q) && $stable(col_q) && $stable(line_q))
    else $error("state moved while disabled");

  // no disable here: the row drivers must see blanking through reset
  row_reset_a: assert property (@(posedge clock)
    rst |-> !row_driver_disable)
    else $error("row disable high in reset");

  // the chain pulse follows the sixteenth shift pulse exactly
  ecl_shift_a: assert property (@(posedge clock) disable iff (rst)
    $rose(column_enable_chain_clock) |-> $past(column_shift_clock) && $past(ecl_q) == ECL_LAST)
    else $error("chain clock off sixteenth pulse");

  // blanking needs one full armed frame first, so never under one frame
  save_arm_a: assert property (@(posedge clock) disable iff (rst)
    $fell(row_driver_disable) |-> $past(save_seen_q))
    else $error("row disable fell before arming");

  // idle after power save keeps the shift clock parked low
  idle_quiet_a: assert property (@(posedge clock) disable iff (rst)
    state_q == LRC_IDLE |=> !column_shift_clock)
    else $error("shift clock ran in idle");
endmodule : lrc_timing
`default_nettype wire
